// File: design/sdram_port_pkg.sv
// Shared constants, types and helpers of the SDRAM port.
// Assumes: imported by strobe_delay and sdram_port.
package sdram_port_pkg;
   localparam int DQ_W_WIDE = 64;
   localparam int DQ_W_NARROW = 16;
   localparam int ADDR_W = 13;
   localparam int BANK_W = 2;
   localparam int NBANK = 4;
   localparam int AP_BIT = 10;
   localparam int APB_AW = 8;
   localparam int APB_DW = 32;
   localparam int LAT_W = 2;
   localparam logic [DQ_W_WIDE-1:0] DQ_MASK_NARROW = 64'h0000_0000_0000_FFFF;

   // Column access latency in memory clocks, and the strobe drain time
   localparam logic [1:0] CAS_LAT_CYC = 2'h3;
   localparam logic [1:0] CAS_LAST = 2'h1;
   localparam logic [1:0] STB_DRAIN = 2'h3;
   localparam logic [1:0] CNT_ZERO = 2'h0;
   localparam logic [1:0] CNT_STEP = 2'h1;

   // Pin codes {select_n, row_strobe_n, column_strobe_n, write_enable_n}
   localparam logic [3:0] PIN_DESEL = 4'hF;
   localparam logic [3:0] PIN_NOP = 4'h7;
   localparam logic [3:0] PIN_ACT = 4'h3;
   localparam logic [3:0] PIN_READ = 4'h5;
   localparam logic [3:0] PIN_WRITE = 4'h4;
   localparam logic [3:0] PIN_PRE = 4'h2;
   localparam logic [3:0] PIN_REF = 4'h1;
   localparam logic [3:0] PIN_MRS = 4'h0;

   // Register byte offsets
   localparam logic [APB_AW-1:0] OFS_CTRL = 8'h00;
   localparam logic [APB_AW-1:0] OFS_CMD = 8'h04;
   localparam logic [APB_AW-1:0] OFS_ADDR = 8'h08;
   localparam logic [APB_AW-1:0] OFS_WDATA = 8'h0C;
   localparam logic [APB_AW-1:0] OFS_RDATA = 8'h10;
   localparam logic [APB_AW-1:0] OFS_STATUS = 8'h14;

   // Field layout and reset values
   localparam int CTRL_W = 4;
   localparam int CTRL_RL_LSB = 0;
   localparam int CTRL_WL_LSB = 2;
   localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;
   localparam int CMD_W = 10;
   localparam int CMD_OP_LSB = 0;
   localparam int CMD_OP_W = 4;
   localparam int CMD_BANK_LSB = 4;
   localparam int CMD_SRC_BIT = 8;
   localparam int CMD_DST_BIT = 9;
   localparam logic [CMD_W-1:0] CMD_RST = 10'h000;
   localparam int STAT_BUSY = 0;
   localparam int STAT_ERR = 1;
   localparam int STAT_OPEN_LSB = 4;
   localparam int STAT_CKE = 8;

   typedef enum logic [3:0] {
      ROW_ACTIVATE_CMD = 4'h0,
      READ_CMD = 4'h1,
      WRITE_CMD = 4'h2,
      CLOSE_ONE_BANK_CMD = 4'h3,
      CLOSE_ALL_BANKS_CMD = 4'h4,
      AUTO_REFRESH_CMD = 4'h5,
      MODE_SET_CMD = 4'h6,
      SELF_ENTER_CMD = 4'h7,
      SELF_EXIT_CMD = 4'h8
   } op_e;

   typedef enum logic [5:0] {
      ST_IDLE = 6'h01,
      ST_CLOSE = 6'h02,
      ST_ISSUE = 6'h04,
      ST_WAIT = 6'h08,
      ST_DATA = 6'h10,
      ST_DONE = 6'h20
   } st_e;

   function automatic logic [NBANK-1:0] bank_bit(input logic [BANK_W-1:0] b);
      return 4'h1 << b;
   endfunction : bank_bit

   function automatic logic [3:0] pin_code(input op_e op);
      case (op)
         ROW_ACTIVATE_CMD: return PIN_ACT;
         READ_CMD: return PIN_READ;
         WRITE_CMD: return PIN_WRITE;
         CLOSE_ONE_BANK_CMD, CLOSE_ALL_BANKS_CMD: return PIN_PRE;
         AUTO_REFRESH_CMD, SELF_ENTER_CMD: return PIN_REF;
         MODE_SET_CMD: return PIN_MRS;
         default: return PIN_NOP;
      endcase
   endfunction : pin_code
endpackage : sdram_port_pkg

// File: design/xfer_strobe_if.sv
// Carrier between the sequencer and the direct-transfer strobe delay.
// Assumes: both ends run on the memory clock.
`timescale 1ns/1ps
interface xfer_strobe_if;
   logic phase;
   logic [1:0] lat;
   logic strobe;
   modport gen (input phase, input lat, output strobe);
   modport user (output phase, output lat, input strobe);
endinterface : xfer_strobe_if

// File: design/level_sync.sv
// Two-flop synchroniser for a level or a toggle.
// Assumes: the input is quasi-static relative to the destination clock.
`timescale 1ns/1ps
module level_sync (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_d,
   output logic o_q
);
   logic meta_r;
   logic sync_r;

   // First flop feeds only the second
   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         meta_r <= 1'b0;
         sync_r <= 1'b0;
      end else begin
         meta_r <= i_d;
         sync_r <= meta_r;
      end
   end

   assign o_q = sync_r;
endmodule : level_sync

// File: design/strobe_delay.sv
// Delays the direct-transfer data phase by 0 to 3 memory clocks.
// Assumes: latency code stays steady for a whole transfer.
`timescale 1ns/1ps
module strobe_delay (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_ce,
   xfer_strobe_if.gen io
);
   import sdram_port_pkg::*;

   logic [2:0] sh_r;

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         sh_r <= 3'h0;
      end else if (i_ce) begin
         sh_r <= {sh_r[1:0], io.phase};
      end
   end

   // Code 0 passes the phase flop straight through
   assign io.strobe = (io.lat == CNT_ZERO) ? io.phase : sh_r[io.lat - CNT_STEP];

   default clocking dc @(posedge i_clk); endclocking
   default disable iff (!i_rst_b || !i_ce);

   zero_latency_a: assert property (
      (io.phase && io.lat == 2'h0) |-> io.strobe)
      else $error("strobe missing at zero latency");
   max_latency_a: assert property (
      (io.phase && io.lat == 2'h3) |-> !io.strobe ##3 io.strobe)
      else $error("strobe not delayed by three cycles");
endmodule : strobe_delay

// File: design/sdram_port.sv
// SDRAM command port with direct-transfer strobe, APB register front end.
// Assumes: APB on i_clk; SDRAM and peripheral timed by i_mem_clk.
// How it works
// - Shared strobes act as column, write, row
// - Read strobe only with source bit set
// - Write strobe only with destination bit set
// - Direct read leaves captured data untouched
// - Read strobe delayed 0-3 by read latency
// - Direct write keeps data bus undriven
// - Write strobe delayed 0-3 by write latency
// - Read data captured three clocks after read
// - Row activate precedes access to that row
// - Close-all-banks precharge closes every row
// - Single-bank close shuts addressed bank only
// - Clock enable driven only by wide bus
// - Auto refresh and mode set issued
// - Self refresh only on wide bus
`timescale 1ns/1ps
module sdram_port #(
   parameter bit WIDE_BUS = 1'b1
) (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic i_ce,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [sdram_port_pkg::APB_AW-1:0] i_paddr,
   input wire logic [sdram_port_pkg::APB_DW-1:0] i_pwdata,
   output logic [sdram_port_pkg::APB_DW-1:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire logic i_mem_clk,
   output logic o_memory_clock_out,
   output logic o_memory_clock_enable,
   output logic o_space_select_n,
   output logic o_row_strobe_n,
   output logic o_column_strobe_n,
   output logic o_sdram_write_enable_n,
   output logic [sdram_port_pkg::ADDR_W-1:0] o_addr,
   output logic [sdram_port_pkg::BANK_W-1:0] o_bank,
   output logic [sdram_port_pkg::DQ_W_WIDE-1:0] o_dq,
   output logic o_dq_oe,
   input wire logic [sdram_port_pkg::DQ_W_WIDE-1:0] i_dq,
   output logic o_direct_transfer_strobe
);
   import sdram_port_pkg::*;

   localparam logic [DQ_W_WIDE-1:0] DQ_MASK = WIDE_BUS ? '1 : DQ_MASK_NARROW;

   // Bus side state
   logic [CTRL_W-1:0] ctrl_r;
   logic [CMD_W-1:0] cmd_r;
   logic [ADDR_W-1:0] addr_r;
   logic [APB_DW-1:0] wdata_r;
   logic [APB_DW-1:0] prdata_r;
   logic req_tgl_r;
   logic done_lvl;

   // Memory side state
   logic done_tgl_r;
   logic req_lvl;
   logic ce_m;
   st_e state_r;
   st_e state_nxt;
   logic [NBANK-1:0] open_r;
   logic [NBANK-1:0] open_nxt;
   logic [ADDR_W-1:0] row_r [NBANK];
   logic [1:0] cnt_r;
   logic [1:0] cnt_nxt;
   logic [3:0] pin_r;
   logic [3:0] pin_nxt;
   logic [ADDR_W-1:0] maddr_r;
   logic [ADDR_W-1:0] maddr_nxt;
   logic [BANK_W-1:0] mbank_r;
   logic [DQ_W_WIDE-1:0] dq_r;
   logic dq_oe_r;
   logic dq_oe_nxt;
   logic cke_r;
   logic cke_nxt;
   logic phase_r;
   logic phase_nxt;
   logic [APB_DW-1:0] rdata_r;
   logic err_r;
   logic err_nxt;

   // APB decode
   wire access = i_psel & i_penable & i_ce;
   wire setup = i_psel & ~i_penable & i_ce;
   wire hit_ctrl = (i_paddr == OFS_CTRL);
   wire hit_cmd = (i_paddr == OFS_CMD);
   wire hit_addr = (i_paddr == OFS_ADDR);
   wire hit_wdata = (i_paddr == OFS_WDATA);
   wire hit_rdata = (i_paddr == OFS_RDATA);
   wire hit_stat = (i_paddr == OFS_STATUS);
   wire mapped = hit_ctrl | hit_cmd | hit_addr | hit_wdata | hit_rdata
      | hit_stat;
   // Busy is a level compare, so nothing is lost while the enable is low
   wire busy = req_tgl_r ^ done_lvl;
   // Command fields must hold still while the memory side reads them
   wire wr_bad = i_pwrite & (hit_rdata | hit_stat | busy);
   wire wr_ok = access & i_pwrite & mapped & ~wr_bad;

   logic [APB_DW-1:0] stat_w;
   always_comb begin
      stat_w = '0;
      stat_w[STAT_BUSY] = busy;
      stat_w[STAT_ERR] = err_r;
      stat_w[STAT_OPEN_LSB +: NBANK] = open_r;
      stat_w[STAT_CKE] = cke_r;
   end

   // Memory side values are read back as they stand, even while busy is set
   wire [APB_DW-1:0] rd_mux =
      hit_ctrl ? APB_DW'(ctrl_r) :
      hit_cmd ? APB_DW'(cmd_r) :
      hit_addr ? APB_DW'(addr_r) :
      hit_wdata ? wdata_r :
      hit_rdata ? rdata_r :
      hit_stat ? stat_w : '0;

   assign o_pready = i_ce;
   assign o_pslverr = i_psel & i_penable & i_ce & (~mapped | wr_bad);
   assign o_prdata = prdata_r;

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ctrl_r <= CTRL_RST;
         cmd_r <= CMD_RST;
         addr_r <= '0;
         wdata_r <= '0;
         prdata_r <= '0;
         req_tgl_r <= 1'b0;
      end else begin
         if (setup) begin
            prdata_r <= rd_mux;
         end
         if (wr_ok & hit_ctrl) begin
            ctrl_r <= i_pwdata[CTRL_W-1:0];
         end
         if (wr_ok & hit_cmd) begin
            cmd_r <= i_pwdata[CMD_W-1:0];
            req_tgl_r <= ~req_tgl_r;
         end
         if (wr_ok & hit_addr) begin
            addr_r <= i_pwdata[ADDR_W-1:0];
         end
         if (wr_ok & hit_wdata) begin
            wdata_r <= i_pwdata;
         end
      end
   end

   // Crossings: request and done toggles, and the clock enable level
   level_sync u_done_sync (
      .i_clk(i_clk),
      .i_rst_b(i_rst_b),
      .i_d(done_tgl_r),
      .o_q(done_lvl)
   );
   level_sync u_req_sync (
      .i_clk(i_mem_clk),
      .i_rst_b(i_rst_b),
      .i_d(req_tgl_r),
      .o_q(req_lvl)
   );
   level_sync u_ce_sync (
      .i_clk(i_mem_clk),
      .i_rst_b(i_rst_b),
      .i_d(i_ce),
      .o_q(ce_m)
   );

   // Command fields, stable for the whole request
   wire [CMD_OP_W-1:0] op_raw = cmd_r[CMD_OP_LSB +: CMD_OP_W];
   wire op_e op = op_e'(op_raw);
   wire [BANK_W-1:0] bank = cmd_r[CMD_BANK_LSB +: BANK_W];
   wire src = cmd_r[CMD_SRC_BIT];
   wire dst = cmd_r[CMD_DST_BIT];
   wire is_rd = (op == READ_CMD);
   wire is_wr = (op == WRITE_CMD);
   wire is_act = (op == ROW_ACTIVATE_CMD);
   wire pending = req_lvl ^ done_tgl_r;
   wire [NBANK-1:0] bbit = bank_bit(bank);
   wire bank_open = |(open_r & bbit);
   wire all_closed_op = (op == AUTO_REFRESH_CMD) | (op == MODE_SET_CMD)
      | (op == SELF_ENTER_CMD);
   wire self_op = (op == SELF_ENTER_CMD) | (op == SELF_EXIT_CMD);
   wire bad_op = ((is_rd | is_wr) & ~bank_open)
      | (all_closed_op & (|open_r))
      | (self_op & ~WIDE_BUS)
      | (~cke_r & (op != SELF_EXIT_CMD))
      | (op_raw > SELF_EXIT_CMD);
   wire row_miss = is_act & bank_open & (row_r[bank] != addr_r);
   wire row_same = is_act & bank_open & ~row_miss;

   // Sequencer
   always_comb begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      pin_nxt = PIN_DESEL;
      maddr_nxt = maddr_r;
      dq_oe_nxt = 1'b0;
      phase_nxt = 1'b0;
      cke_nxt = cke_r;
      open_nxt = open_r;
      err_nxt = err_r;
      unique case (state_r)
         ST_IDLE: begin
            if (pending) begin
               err_nxt = bad_op;
               if (bad_op | row_same) begin
                  state_nxt = ST_DONE;
                  cnt_nxt = STB_DRAIN;
               end else if (row_miss) begin
                  state_nxt = ST_CLOSE;
               end else begin
                  state_nxt = ST_ISSUE;
               end
            end
         end
         ST_CLOSE: begin
            pin_nxt = PIN_PRE;
            maddr_nxt = '0;
            open_nxt = open_r & ~bbit;
            state_nxt = ST_ISSUE;
         end
         ST_ISSUE: begin
            pin_nxt = pin_code(op);
            maddr_nxt = addr_r;
            if (is_rd | is_wr | (op == CLOSE_ONE_BANK_CMD)) begin
               maddr_nxt[AP_BIT] = 1'b0;
            end
            if (op == CLOSE_ALL_BANKS_CMD) begin
               maddr_nxt[AP_BIT] = 1'b1;
               open_nxt = '0;
            end
            if (is_act) begin
               open_nxt = open_r | bbit;
            end
            if (op == CLOSE_ONE_BANK_CMD) begin
               open_nxt = open_r & ~bbit;
            end
            if (op == SELF_ENTER_CMD) begin
               cke_nxt = 1'b0;
            end
            if (op == SELF_EXIT_CMD) begin
               cke_nxt = 1'b1;
            end
            // Write data rides with the command; direct writes float it
            dq_oe_nxt = is_wr & ~dst;
            phase_nxt = is_wr & dst;
            if (is_rd) begin
               cnt_nxt = CAS_LAT_CYC;
               state_nxt = ST_WAIT;
            end else begin
               cnt_nxt = STB_DRAIN;
               state_nxt = ST_DONE;
            end
         end
         ST_WAIT: begin
            pin_nxt = PIN_NOP;
            if (cnt_r == CAS_LAST) begin
               state_nxt = ST_DATA;
               phase_nxt = src;
            end else begin
               cnt_nxt = cnt_r - CNT_STEP;
            end
         end
         ST_DATA: begin
            pin_nxt = PIN_NOP;
            cnt_nxt = STB_DRAIN;
            state_nxt = ST_DONE;
         end
         ST_DONE: begin
            // Holds the command until a delayed strobe has gone out
            if (cnt_r == CNT_ZERO) begin
               state_nxt = ST_IDLE;
            end else begin
               cnt_nxt = cnt_r - CNT_STEP;
            end
         end
      endcase
   end

   always_ff @(posedge i_mem_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state_r <= ST_IDLE;
         cnt_r <= CNT_ZERO;
         pin_r <= PIN_DESEL;
         maddr_r <= '0;
         mbank_r <= '0;
         dq_oe_r <= 1'b0;
         phase_r <= 1'b0;
         cke_r <= 1'b1;
         open_r <= '0;
         err_r <= 1'b0;
         done_tgl_r <= 1'b0;
      end else if (ce_m) begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         pin_r <= pin_nxt;
         maddr_r <= maddr_nxt;
         dq_oe_r <= dq_oe_nxt;
         phase_r <= phase_nxt;
         cke_r <= cke_nxt;
         open_r <= open_nxt;
         err_r <= err_nxt;
         if (state_r == ST_CLOSE || state_r == ST_ISSUE) begin
            mbank_r <= bank;
         end
         if (state_r == ST_DONE && cnt_r == CNT_ZERO) begin
            done_tgl_r <= ~done_tgl_r;
         end
      end
   end

   // Data path; rows need no reset since they are read only when open
   always_ff @(posedge i_mem_clk) begin
      if (ce_m && state_r == ST_ISSUE && is_act) begin
         row_r[bank] <= addr_r;
      end
   end

   always_ff @(posedge i_mem_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         dq_r <= '0;
         rdata_r <= '0;
      end else if (ce_m) begin
         if (state_r == ST_ISSUE && is_wr) begin
            dq_r <= {2{wdata_r}} & DQ_MASK;
         end
         if (state_r == ST_DATA && !src) begin
            rdata_r <= i_dq[APB_DW-1:0] & DQ_MASK[APB_DW-1:0];
         end
      end
   end

   // Direct-transfer strobe timing
   xfer_strobe_if u_stb_if ();
   assign u_stb_if.phase = phase_r;
   assign u_stb_if.lat = is_rd ? ctrl_r[CTRL_RL_LSB +: LAT_W]
      : ctrl_r[CTRL_WL_LSB +: LAT_W];

   strobe_delay u_stb_dly (
      .i_clk(i_mem_clk),
      .i_rst_b(i_rst_b),
      .i_ce(ce_m),
      .io(u_stb_if.gen)
   );

   // Shared strobes carry the SDRAM roles on every command
   assign {o_space_select_n, o_row_strobe_n, o_column_strobe_n,
      o_sdram_write_enable_n} = pin_r;
   assign o_addr = maddr_r;
   assign o_bank = mbank_r;
   assign o_dq = dq_r;
   assign o_dq_oe = dq_oe_r;
   assign o_direct_transfer_strobe = u_stb_if.strobe;
   assign o_memory_clock_enable = WIDE_BUS ? cke_r : 1'b0;
   assign o_memory_clock_out = i_mem_clk;

   default clocking mc @(posedge i_mem_clk); endclocking
   default disable iff (!i_rst_b || !ce_m);

   cas_latency_a: assert property (
      (pin_r == PIN_READ) |-> ##3 (state_r == ST_DATA))
      else $error("read data not captured three clocks after read");
   activate_first_a: assert property (
      (pin_r == PIN_READ || pin_r == PIN_WRITE)
      |-> (open_r & bank_bit(o_bank)) != '0)
      else $error("access to a bank with no open row");
   close_all_a: assert property (
      (pin_r == PIN_PRE && o_addr[AP_BIT]) |-> open_r == '0)
      else $error("close-all left a row open");
   close_one_a: assert property (
      (pin_r == PIN_PRE && !o_addr[AP_BIT])
      |-> (open_r & bank_bit(o_bank)) == '0)
      else $error("single close left the bank open");
   close_before_a: assert property (
      (pin_r == PIN_ACT) |-> ($past(open_r) & bank_bit(o_bank)) == '0)
      else $error("activate on a bank with an open row");
   refresh_idle_a: assert property (
      (pin_r == PIN_REF || pin_r == PIN_MRS) |-> open_r == '0)
      else $error("refresh or mode set with rows open");
   self_refresh_a: assert property (
      $fell(cke_r) |-> (pin_r == PIN_REF && WIDE_BUS))
      else $error("clock enable dropped without self refresh");
   strobe_source_a: assert property (
      phase_r |-> (is_rd ? src : dst))
      else $error("direct strobe without its option bit");
   write_float_a: assert property (
      (pin_r == PIN_WRITE && dst) |-> !o_dq_oe)
      else $error("data bus driven on a direct write");
   no_latch_a: assert property (
      (state_r == ST_DATA && src) |=> $stable(rdata_r))
      else $error("direct read data was captured");
endmodule : sdram_port

// File: tb/sdram_model.sv
// Behavioural SDRAM plus direct-transfer peripheral on the memory pins.
// Assumes: commands sampled on the forwarded memory clock, CAS latency 3.
`timescale 1ns/1ps
module sdram_model (
   input wire logic i_clk,
   input wire logic [3:0] i_cmd,
   input wire logic [sdram_port_pkg::ADDR_W-1:0] i_addr,
   input wire logic [sdram_port_pkg::BANK_W-1:0] i_bank,
   input wire logic [sdram_port_pkg::DQ_W_WIDE-1:0] i_dq,
   input wire logic i_dq_oe,
   input wire logic i_strobe,
   input wire logic [31:0] i_rd_word,
   output logic [sdram_port_pkg::DQ_W_WIDE-1:0] o_dq,
   output logic [7:0] o_cmds,
   output logic [sdram_port_pkg::ADDR_W-1:0] o_addr,
   output logic [sdram_port_pkg::BANK_W-1:0] o_bank,
   output logic o_oe,
   output logic [sdram_port_pkg::DQ_W_WIDE-1:0] o_wdata,
   output logic [7:0] o_gap,
   output logic [7:0] o_n_strobe
);
   import sdram_port_pkg::*;
   logic [2:0] rd_sh = '0;
   logic [7:0] since = '0;
   logic is_rw;
   initial begin
      o_dq = '0;
      o_cmds = 8'hFF;
      o_n_strobe = '0;
      o_gap = '0;
   end
   assign is_rw = (i_cmd == PIN_READ) || (i_cmd == PIN_WRITE);
   always @(posedge i_clk) begin
      rd_sh <= {rd_sh[1:0], i_cmd == PIN_READ};
      // Data valid at the third edge after the read was taken
      if (rd_sh[1]) begin
         o_dq <= {2{i_rd_word}};
      end else begin
         // Idle bus flips so a stale value can never pass for data
         o_dq <= ~o_dq;
      end
      since <= since + 8'h01;
      if (i_cmd != PIN_NOP && i_cmd != PIN_DESEL) begin
         o_cmds <= {o_cmds[3:0], i_cmd};
         o_addr <= i_addr;
         o_bank <= i_bank;
      end
      if (is_rw) begin
         since <= 8'h01;
      end
      if (i_cmd == PIN_WRITE) begin
         o_oe <= i_dq_oe;
         o_wdata <= i_dq;
      end
      if (i_strobe) begin
         o_gap <= is_rw ? 8'h00 : since;
         o_n_strobe <= o_n_strobe + 8'h01;
      end
   end
endmodule : sdram_model

// File: tb/testbench.sv
// Self-checking bench for the wide SDRAM port driven over APB.
// Assumes: the package and the model are compiled before this file.
`timescale 1ns/1ps
`define CHK(a, e) begin \
   comparisons++; \
   if ((a) !== (e)) begin \
      n_mismatch++; \
      $display("CHECK FAILED t=%0t got %0h exp %0h", $time, a, e); \
   end \
end
module testbench;
   import sdram_port_pkg::*;
   logic i_clk = 1'b0;
   logic i_mem_clk = 1'b0;
   logic i_rst_b = 1'b0;
   logic i_ce = 1'b1;
   logic i_psel = 1'b0;
   logic i_penable = 1'b0;
   logic i_pwrite = 1'b0;
   logic [APB_AW-1:0] i_paddr = '0;
   logic [APB_DW-1:0] i_pwdata = '0;
   logic [APB_DW-1:0] o_prdata;
   logic o_pready, o_pslverr, o_memory_clock_out, o_memory_clock_enable;
   logic o_space_select_n, o_row_strobe_n, o_column_strobe_n, o_dq_oe;
   logic o_sdram_write_enable_n, o_direct_transfer_strobe, m_oe, e, n_cke;
   logic [ADDR_W-1:0] o_addr, m_addr, row;
   logic [BANK_W-1:0] o_bank, m_bank, b;
   logic [DQ_W_WIDE-1:0] o_dq, i_dq, m_wdata;
   logic [7:0] m_cmds, m_gap, m_nstb, n0;
   logic [31:0] rd_word = '0;
   logic [31:0] st, q, w, old, n_prdata;
   int n_mismatch = 0;
   int comparisons = 0;

   always #12.5 i_clk = ~i_clk;
   // Odd offset keeps the two clock domains' edges apart
   initial begin
      #7;
      forever #62.5 i_mem_clk = ~i_mem_clk;
   end

   sdram_port #(.WIDE_BUS(1'b1)) i_sdram_port (.i_clk, .i_rst_b, .i_ce,
      .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata,
      .o_pready, .o_pslverr, .i_mem_clk, .o_memory_clock_out,
      .o_memory_clock_enable, .o_space_select_n, .o_row_strobe_n,
      .o_column_strobe_n, .o_sdram_write_enable_n, .o_addr, .o_bank,
      .o_dq, .o_dq_oe, .i_dq, .o_direct_transfer_strobe);

   // Narrow twin on the same bus; its clock enable must stay low
   sdram_port #(.WIDE_BUS(1'b0)) i_sdram_port_n (.i_clk, .i_rst_b, .i_ce,
      .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata,
      .o_prdata(n_prdata), .o_pready(), .o_pslverr(), .i_mem_clk,
      .o_memory_clock_out(), .o_memory_clock_enable(n_cke),
      .o_space_select_n(), .o_row_strobe_n(), .o_column_strobe_n(),
      .o_sdram_write_enable_n(), .o_addr(), .o_bank(), .o_dq(),
      .o_dq_oe(), .i_dq, .o_direct_transfer_strobe());

   sdram_model i_sdram_model (.i_clk(o_memory_clock_out),
      .i_cmd({o_space_select_n, o_row_strobe_n, o_column_strobe_n,
         o_sdram_write_enable_n}),
      .i_addr(o_addr), .i_bank(o_bank), .i_dq(o_dq), .i_dq_oe(o_dq_oe),
      .i_strobe(o_direct_transfer_strobe), .i_rd_word(rd_word),
      .o_dq(i_dq), .o_cmds(m_cmds), .o_addr(m_addr), .o_bank(m_bank),
      .o_oe(m_oe), .o_wdata(m_wdata), .o_gap(m_gap), .o_n_strobe(m_nstb));

   function automatic logic [3:0] open_of(input logic [1:0] bk);
      return 4'h1 << bk;
   endfunction : open_of

   // Answer is taken at the rising edge that finds pready high
   task automatic apb(input logic wr, input logic [7:0] a,
         input logic [31:0] d, output logic [31:0] rq, output logic re);
      @(posedge i_clk);
      i_psel <= 1'b1;
      i_penable <= 1'b0;
      i_pwrite <= wr;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_clk);
      i_penable <= 1'b1;
      do begin
         @(posedge i_clk);
      end while (o_pready !== 1'b1);
      rq = o_prdata;
      re = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask : apb

   task automatic cmd(input op_e op, input logic [1:0] bk,
         input logic [1:0] dir);
      int n;
      apb(1'b1, OFS_CMD, {22'h0, dir, 2'h0, bk, op}, q, e);
      repeat (4) @(posedge i_clk);
      n = 0;
      do begin
         apb(1'b0, OFS_STATUS, 32'h0, st, e);
         n++;
      end while (st[STAT_BUSY] !== 1'b0 && n < 200);
      `CHK(st[STAT_BUSY], 1'b0)
   endtask : cmd

   task automatic final_report;
      $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : final_report

   initial begin
      repeat (30000) @(posedge i_clk);
      n_mismatch++;
      final_report();
   end

   initial begin
      rd_word = $urandom(32'h0F1C);
      repeat (4) @(posedge i_clk);
      i_rst_b <= 1'b1;
      repeat (20) @(posedge i_clk);
      apb(1'b0, OFS_CTRL, 32'h0, q, e);
      `CHK(q, 32'h0)
      apb(1'b0, OFS_STATUS, 32'h0, q, e);
      `CHK(q, 32'h100)
      `CHK({o_memory_clock_enable, n_cke}, 2'b10)
      apb(1'b0, 8'h40, 32'h0, q, e);
      `CHK({e, q}, 33'h100000000)
      apb(1'b1, OFS_RDATA, $urandom, q, e);
      `CHK(e, 1'b1)
      // A low enable must hold the bus answer back
      i_ce <= 1'b0;
      repeat (12) @(posedge i_clk);
      `CHK({o_pready, o_pslverr}, 2'b00)
      i_ce <= 1'b1;
      $display("test registers done");
      b = $urandom;
      row = $urandom;
      apb(1'b1, OFS_ADDR, {19'h0, row}, q, e);
      cmd(ROW_ACTIVATE_CMD, b, 2'h0);
      `CHK(m_cmds[3:0], PIN_ACT)
      `CHK({m_bank, m_addr}, {b, row})
      `CHK(st[7:4], open_of(b))
      // Destination bit on a read must not raise the strobe
      n0 = m_nstb;
      rd_word <= $urandom;
      apb(1'b1, OFS_ADDR, {19'h0, row}, q, e);
      cmd(READ_CMD, b, 2'h2);
      apb(1'b0, OFS_RDATA, 32'h0, old, e);
      `CHK(m_cmds[3:0], PIN_READ)
      `CHK(m_addr, row & 13'h1BFF)
      `CHK(old, rd_word)
      `CHK(n_prdata, rd_word & 32'hFFFF)
      `CHK(m_nstb, n0)
      w = $urandom;
      apb(1'b1, OFS_WDATA, w, q, e);
      cmd(WRITE_CMD, b, 2'h1);
      `CHK({m_cmds[3:0], m_oe}, {PIN_WRITE, 1'b1})
      `CHK(m_wdata, {w, w})
      `CHK(m_nstb, n0)
      $display("test normal access done");
      for (int lat = 0; lat < 4; lat++) begin
         apb(1'b1, OFS_CTRL, lat * 5, q, e);
         apb(1'b0, OFS_CTRL, 32'h0, q, e);
         `CHK(q, lat * 5)
         rd_word <= $urandom;
         cmd(READ_CMD, b, 2'h1);
         apb(1'b0, OFS_RDATA, 32'h0, q, e);
         `CHK(q, old)
         `CHK(m_nstb, n0 + 8'h01)
         `CHK(m_gap, 8'(lat + 3))
         apb(1'b1, OFS_WDATA, $urandom, q, e);
         cmd(WRITE_CMD, b, 2'h2);
         `CHK(m_oe, 1'b0)
         `CHK(m_nstb, n0 + 8'h02)
         `CHK(m_gap, 8'(lat))
         n0 = m_nstb;
      end
      $display("test direct transfer done");
      apb(1'b1, OFS_ADDR, {19'h0, ~row}, q, e);
      cmd(ROW_ACTIVATE_CMD, b, 2'h0);
      `CHK(m_cmds, {PIN_PRE, PIN_ACT})
      `CHK(m_addr, ~row)
      cmd(ROW_ACTIVATE_CMD, b + 2'h1, 2'h0);
      cmd(CLOSE_ONE_BANK_CMD, b, 2'h0);
      `CHK({m_cmds[3:0], m_bank, m_addr[AP_BIT]}, {PIN_PRE, b, 1'b0})
      `CHK(st[7:4], open_of(b + 2'h1))
      cmd(CLOSE_ALL_BANKS_CMD, b, 2'h0);
      `CHK({m_cmds[3:0], m_addr[AP_BIT]}, {PIN_PRE, 1'b1})
      `CHK(st[7:4], 4'h0)
      cmd(READ_CMD, b, 2'h0);
      `CHK({m_cmds[3:0], st[STAT_ERR]}, {PIN_PRE, 1'b1})
      $display("test bank close done");
      cmd(AUTO_REFRESH_CMD, b, 2'h0);
      `CHK({m_cmds[3:0], st[STAT_ERR]}, {PIN_REF, 1'b0})
      row = $urandom;
      apb(1'b1, OFS_ADDR, {19'h0, row}, q, e);
      cmd(MODE_SET_CMD, b, 2'h0);
      `CHK({m_cmds[3:0], m_addr}, {PIN_MRS, row})
      cmd(SELF_ENTER_CMD, b, 2'h0);
      `CHK({o_memory_clock_enable, st[STAT_CKE], n_cke}, 3'b000)
      cmd(SELF_EXIT_CMD, b, 2'h0);
      `CHK({o_memory_clock_enable, st[STAT_CKE]}, 2'b11)
      $display("test refresh done");
      final_report();
   end
endmodule : testbench
